/* logic/tps_serial_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Address LSB zero writes, one reads
// - Four addresses selected by address pins
// - Acknowledge a matching address byte
// - Acknowledge every received write data byte
// - First bit zero means divider data
// - Commit at end of every count-low, control and port byte
// - Divider pair applied as one update
// - More bytes may follow until stop
// - Abort keeps latched bytes, drops a lone count byte
// - Pair carries marker plus fifteen-bit count
// - Output reference ratio and twice-count multiplier
// - Control bit 2 selects pump current
// - Control bit 3 test mode, 5-6 function
// - Control bit 4 switches pump off
// - Control bit 7 picks divide 128 or 64
// - Control bit 8 turns amplifier off
// - Port bits 1,3,4 drive general ports
// - Port bit 2 selects IF output
// - Port bit 8 drives band switch
// - Power-up flag sets, clears after read
// - Status bit 2 reports lock
// - Status bits 3-5 report comparator levels
// - Five fixed address bits, two from pins
// - General port bit one means on
module tps_serial_ctrl
  import tps_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        scl_pin,
  input  wire logic        sda_pin_in,
  output var  logic        sda_pin_out,
  output var  logic        sda_pin_oe,
  input  wire logic        hw_address_bit_hi,
  input  wire logic        hw_address_bit_lo,
  input  wire logic        lock_detect_in,
  input  wire logic        level_in_a,
  input  wire logic        level_in_b,
  input  wire logic        level_in_c,
  input  wire logic        supply_ok,
  output var  logic [14:0] loop_divider_count,
  output var  logic        pump_current_select,
  output var  logic        test_mode_enable,
  output var  logic        pump_disable,
  output var  logic        test_select_hi,
  output var  logic        test_select_lo,
  output var  logic        ref_divider_select,
  output var  logic        tuning_amp_disable,
  output var  logic [7:0]  ref_div_ratio,
  output var  logic [15:0] synth_multiplier,
  output var  logic        gen_port_a,
  output var  logic        gen_port_b,
  output var  logic        gen_port_c,
  output var  logic        if_output_select,
  output var  logic        band_switch_out,
  output var  logic        pll_locked_status
);

  // ==========================================================================
  // Pin synchronisation
  // ==========================================================================
  logic [TPS_SYNC_W-1:0] pins_raw;
  logic [TPS_SYNC_W-1:0] pins_s;

  assign pins_raw = {supply_ok, level_in_c, level_in_b, level_in_a, lock_detect_in,
                     hw_address_bit_hi, hw_address_bit_lo, sda_pin_in, scl_pin};

  tps_sync u_sync (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .async_in (pins_raw),
    .sync_out (pins_s)
  );

  logic       scl_s;
  logic       sda_s;
  logic [1:0] hw_addr_s;
  logic       lock_s;
  logic [2:0] level_s;
  logic       supply_s;

  // Named views of the synchronised pins
  assign scl_s     = pins_s[0];
  assign sda_s     = pins_s[1];
  assign hw_addr_s = pins_s[3:2];
  assign lock_s    = pins_s[4];
  assign level_s   = pins_s[7:5];
  assign supply_s  = pins_s[8];

  // ==========================================================================
  // Bus condition detection
  // ==========================================================================
  logic scl_prev_q;
  logic sda_prev_q;

  // Previous samples for edge detection
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // Slow bus edges are safe: data only changes while the clock is low
  assign scl_rise  = scl_s & ~scl_prev_q;
  assign scl_fall  = ~scl_s & scl_prev_q;
  assign bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign bus_stop  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // ==========================================================================
  // Protocol engine
  // ==========================================================================
  tps_state_t state_q;
  tps_state_t state_d;
  logic [2:0] bit_cnt_q;
  logic [2:0] bit_cnt_d;
  logic [7:0] rx_shift_q;
  logic [7:0] rx_shift_d;
  logic [7:0] tx_shift_q;
  logic [7:0] tx_shift_d;
  logic       drive_low_q;
  logic       drive_low_d;
  logic       read_dir_q;
  logic       read_dir_d;
  logic       ack_pend_q;
  logic       ack_pend_d;
  logic       master_ack_q;
  logic       master_ack_d;
  logic       por_flag_q;

  logic [7:0] rx_byte;
  logic       byte_done;
  logic       addr_match;
  logic       data_strobe;
  logic       read_done;

  // Assemble the status byte
  function automatic logic [7:0] tps_status(input logic por, input logic lock, input logic [2:0] lvl);
    tps_status = {por, lock, lvl[2], lvl[1], lvl[0], TPS_STATUS_PAD};
  endfunction : tps_status

  logic [7:0] status_now;

  assign status_now  = tps_status(por_flag_q, lock_s, level_s);
  assign rx_byte     = {rx_shift_q[6:0], sda_s};
  assign byte_done   = scl_rise & (bit_cnt_q == TPS_LAST_BIT);
  // Fixed prefix plus the two pin-selected bits
  assign addr_match  = (rx_byte[7:3] == TPS_ADDR_FIXED) & (rx_byte[2:1] == hw_addr_s);
  assign data_strobe = (state_q == TPS_ST_WDATA) & byte_done & ~bus_start & ~bus_stop;
  assign read_done   = (state_q == TPS_ST_RDATA) & scl_fall & (bit_cnt_q == TPS_LAST_BIT);

  // Next-state logic; start and stop override any state
  always_comb begin
    state_d      = state_q;
    bit_cnt_d    = bit_cnt_q;
    rx_shift_d   = rx_shift_q;
    tx_shift_d   = tx_shift_q;
    drive_low_d  = drive_low_q;
    read_dir_d   = read_dir_q;
    ack_pend_d   = ack_pend_q;
    master_ack_d = master_ack_q;
    if (bus_start) begin
      state_d     = TPS_ST_ADDR;
      bit_cnt_d   = TPS_CNT_ZERO;
      drive_low_d = 1'b0;
      ack_pend_d  = 1'b0;
    end else if (bus_stop) begin
      state_d     = TPS_ST_IDLE;
      drive_low_d = 1'b0;
      ack_pend_d  = 1'b0;
    end else begin
      case (state_q)
        TPS_ST_ADDR, TPS_ST_WDATA: begin
          if (scl_rise) begin
            rx_shift_d = rx_byte;
            bit_cnt_d  = bit_cnt_q + TPS_CNT_ONE;
          end
          if (byte_done) begin
            if (state_q == TPS_ST_WDATA) begin
              ack_pend_d = 1'b1;
            end else if (addr_match) begin
              ack_pend_d = 1'b1;
              read_dir_d = (rx_byte[TPS_RW_BIT] == TPS_RW_READ);
            end else begin
              state_d = TPS_ST_IDLE;
            end
          end
          if (scl_fall && ack_pend_q) begin
            state_d     = TPS_ST_ACK;
            drive_low_d = 1'b1;
            ack_pend_d  = 1'b0;
          end
        end
        TPS_ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_d = TPS_CNT_ZERO;
            if (read_dir_q) begin
              state_d     = TPS_ST_RDATA;
              tx_shift_d  = status_now;
              drive_low_d = ~status_now[TPS_TYPE_BIT];
            end else begin
              state_d     = TPS_ST_WDATA;
              drive_low_d = 1'b0;
            end
          end
        end
        TPS_ST_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt_q == TPS_LAST_BIT) begin
              state_d     = TPS_ST_RACK;
              drive_low_d = 1'b0;
            end else begin
              tx_shift_d  = {tx_shift_q[6:0], 1'b0};
              drive_low_d = ~tx_shift_q[TPS_TYPE_BIT-1];
              bit_cnt_d   = bit_cnt_q + TPS_CNT_ONE;
            end
          end
        end
        TPS_ST_RACK: begin
          if (scl_rise) begin
            master_ack_d = ~sda_s;
          end
          if (scl_fall) begin
            bit_cnt_d = TPS_CNT_ZERO;
            if (master_ack_q) begin
              state_d     = TPS_ST_RDATA;
              tx_shift_d  = status_now;
              drive_low_d = ~status_now[TPS_TYPE_BIT];
            end else begin
              state_d = TPS_ST_IDLE;
            end
          end
        end
        default: begin
          state_d     = TPS_ST_IDLE;
          drive_low_d = 1'b0;
        end
      endcase
    end
  end

  // Engine registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q      <= TPS_ST_IDLE;
      bit_cnt_q    <= TPS_CNT_ZERO;
      rx_shift_q   <= 8'h00;
      tx_shift_q   <= 8'h00;
      drive_low_q  <= 1'b0;
      read_dir_q   <= 1'b0;
      ack_pend_q   <= 1'b0;
      master_ack_q <= 1'b0;
    end else begin
      state_q      <= state_d;
      bit_cnt_q    <= bit_cnt_d;
      rx_shift_q   <= rx_shift_d;
      tx_shift_q   <= tx_shift_d;
      drive_low_q  <= drive_low_d;
      read_dir_q   <= read_dir_d;
      ack_pend_q   <= ack_pend_d;
      master_ack_q <= master_ack_d;
    end
  end

  // ==========================================================================
  // Power-up flag
  // ==========================================================================
  // Supply loss wins over the clear so a dip during a read is not missed
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      por_flag_q <= 1'b1;
    end else if (!supply_s) begin
      por_flag_q <= 1'b1;
    end else if (read_done) begin
      por_flag_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Write data latching
  // ==========================================================================
  tps_phase_t  phase_q;
  logic [6:0]  div_hi_q;
  logic [14:0] count_q;
  logic [7:0]  ctl_q;
  logic [7:0]  port_q;

  logic is_div_byte;

  assign is_div_byte = (rx_byte[TPS_TYPE_BIT] == TPS_TYPE_DIV);

  // Divider pairs commit only on completion, control and port bytes each at their own end; a lone count byte dies on start/stop
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      phase_q  <= TPS_PH_CLASSIFY;
      div_hi_q <= 7'h00;
      count_q  <= TPS_RST_COUNT;
      ctl_q    <= TPS_RST_CTL;
      port_q   <= TPS_RST_PORT;
    end else if (bus_start || bus_stop) begin
      phase_q <= TPS_PH_CLASSIFY;
    end else if (data_strobe) begin
      case (phase_q)
        TPS_PH_DIV_LO: begin
          count_q <= {div_hi_q, rx_byte};
          phase_q <= TPS_PH_CLASSIFY;
        end
        TPS_PH_PORT: begin
          port_q  <= rx_byte;
          phase_q <= TPS_PH_CLASSIFY;
        end
        default: begin
          if (is_div_byte) begin
            div_hi_q <= rx_byte[6:0];
            phase_q  <= TPS_PH_DIV_LO;
          end else begin
            ctl_q   <= rx_byte;
            phase_q <= TPS_PH_PORT;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Output register stage
  // ==========================================================================
  logic ports_forced_off;

  // Test combination that forces the general ports off
  assign ports_forced_off = ctl_q[TPS_CTL_T1] & ctl_q[TPS_CTL_TS2] & ctl_q[TPS_CTL_TS1] & ~ctl_q[TPS_CTL_TS0];

  logic [14:0] count_out_q;
  logic [7:0]  ctl_out_q;
  logic [7:0]  ref_ratio_q;
  logic [15:0] mult_q;
  logic [2:0]  gen_ports_q;
  logic        if_sel_q;
  logic        band_q;
  logic        lock_q;
  logic        sda_out_q;
  logic        sda_oe_q;

  // Outputs follow their registers one cycle later, glitch free at the pins
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      count_out_q <= TPS_RST_COUNT;
      ctl_out_q   <= TPS_RST_CTL;
      ref_ratio_q <= TPS_REF_DIV_HI;
      mult_q      <= 16'h0000;
      gen_ports_q <= 3'h0;
      if_sel_q    <= 1'b0;
      band_q      <= 1'b0;
      lock_q      <= 1'b0;
      sda_out_q   <= 1'b0;
      sda_oe_q    <= 1'b0;
    end else begin
      count_out_q <= count_q;
      ctl_out_q   <= ctl_q;
      ref_ratio_q <= ctl_q[TPS_CTL_TS0] ? TPS_REF_DIV_HI : TPS_REF_DIV_LO;
      mult_q      <= {count_q, 1'b0};
      gen_ports_q <= {port_q[TPS_PRT_C], port_q[TPS_PRT_B], port_q[TPS_PRT_A]} & {3{~ports_forced_off}};
      if_sel_q    <= port_q[TPS_PRT_IF];
      band_q      <= port_q[TPS_PRT_BAND];
      lock_q      <= lock_s;
      sda_out_q   <= 1'b0;                 // Open drain: only ever pulls low
      sda_oe_q    <= drive_low_q;
    end
  end

  // Pin and field mapping
  assign loop_divider_count  = count_out_q;
  assign pump_current_select = ctl_out_q[TPS_CTL_CP];
  assign test_mode_enable    = ctl_out_q[TPS_CTL_T1];
  assign pump_disable        = ctl_out_q[TPS_CTL_T0];
  assign test_select_hi      = ctl_out_q[TPS_CTL_TS2];
  assign test_select_lo      = ctl_out_q[TPS_CTL_TS1];
  assign ref_divider_select  = ctl_out_q[TPS_CTL_TS0];
  assign tuning_amp_disable  = ctl_out_q[TPS_CTL_OS];
  assign ref_div_ratio       = ref_ratio_q;
  assign synth_multiplier    = mult_q;
  assign gen_port_c          = gen_ports_q[2];
  assign gen_port_b          = gen_ports_q[1];
  assign gen_port_a          = gen_ports_q[0];
  assign if_output_select    = if_sel_q;
  assign band_switch_out     = band_q;
  assign pll_locked_status   = lock_q;
  assign sda_pin_out         = sda_out_q;
  assign sda_pin_oe          = sda_oe_q;

endmodule : tps_serial_ctrl
`default_nettype wire

/* logic/tps_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Two-flop synchroniser for pin inputs
// ============================================================================
module tps_sync
  import tps_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  srst,
  input  wire logic [TPS_SYNC_W-1:0] async_in,
  output var  logic [TPS_SYNC_W-1:0] sync_out
);

  logic [TPS_SYNC_W-1:0] meta_q;
  logic [TPS_SYNC_W-1:0] stable_q;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_q   <= '0;
      stable_q <= '0;
    end else begin
      meta_q   <= async_in;
      stable_q <= meta_q;
    end
  end

  assign sync_out = stable_q;

endmodule : tps_sync
`default_nettype wire

/* pkg/tps_pkg.sv */
`default_nettype none
package tps_pkg;

  // ==========================================================================
  // Addressing
  // ==========================================================================
  localparam logic [4:0] TPS_ADDR_FIXED = 5'h18;   // Upper five address bits
  localparam int         TPS_RW_BIT     = 0;
  localparam logic       TPS_RW_READ    = 1'b1;
  localparam int         TPS_TYPE_BIT   = 7;       // First bit on the wire
  localparam logic       TPS_TYPE_DIV   = 1'b0;
  localparam logic [2:0] TPS_LAST_BIT   = 3'h7;
  localparam logic [2:0] TPS_CNT_ONE    = 3'h1;
  localparam logic [2:0] TPS_CNT_ZERO   = 3'h0;

  // ==========================================================================
  // Control byte fields (bit 1 on the wire is index 7)
  // ==========================================================================
  localparam int TPS_CTL_CP  = 6;
  localparam int TPS_CTL_T1  = 5;
  localparam int TPS_CTL_T0  = 4;
  localparam int TPS_CTL_TS2 = 3;
  localparam int TPS_CTL_TS1 = 2;
  localparam int TPS_CTL_TS0 = 1;
  localparam int TPS_CTL_OS  = 0;

  // ==========================================================================
  // Port byte fields
  // ==========================================================================
  localparam int TPS_PRT_C    = 7;
  localparam int TPS_PRT_IF   = 6;
  localparam int TPS_PRT_B    = 5;
  localparam int TPS_PRT_A    = 4;
  localparam int TPS_PRT_BAND = 0;

  // ==========================================================================
  // Reset values and constants
  // ==========================================================================
  localparam logic [14:0] TPS_RST_COUNT  = 15'h0000;
  localparam logic [7:0]  TPS_RST_CTL    = 8'h83;  // Step 125 kHz, amp off
  localparam logic [7:0]  TPS_RST_PORT   = 8'h00;
  localparam logic [2:0]  TPS_STATUS_PAD = 3'h7;
  localparam logic [7:0]  TPS_REF_DIV_LO = 8'h80;  // Divide by 128
  localparam logic [7:0]  TPS_REF_DIV_HI = 8'h40;  // Divide by 64
  localparam int          TPS_SYNC_W     = 9;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    TPS_ST_IDLE  = 3'b000,
    TPS_ST_ADDR  = 3'b001,
    TPS_ST_WDATA = 3'b010,
    TPS_ST_ACK   = 3'b011,
    TPS_ST_RDATA = 3'b100,
    TPS_ST_RACK  = 3'b101
  } tps_state_t;

  typedef enum logic [1:0] {
    TPS_PH_CLASSIFY = 2'b00,
    TPS_PH_DIV_LO   = 2'b01,
    TPS_PH_PORT     = 2'b10
  } tps_phase_t;

endpackage : tps_pkg
`default_nettype wire

/* verification/tb_tps_serial_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_tps_serial_ctrl
  import tps_pkg::*;
;
  logic ref_clk = 1'b0, srst = 1'b1, supply_ok = 1'b1, lock_detect_in = 1'b0;
  logic hw_address_bit_hi = 1'b0, hw_address_bit_lo = 1'b0;
  logic level_in_a = 1'b0, level_in_b = 1'b0, level_in_c = 1'b0;
  logic sda_pin_oe, scl_pin, sda_low, res_valid, pump_current_select, test_mode_enable, pump_disable;
  logic test_select_hi, test_select_lo, ref_divider_select, tuning_amp_disable, gen_port_a, gen_port_b;
  logic gen_port_c, if_output_select, band_switch_out, pll_locked_status;
  logic [8:0]  res_data, exp_bus;
  logic [14:0] loop_divider_count, m_cnt;
  logic [15:0] synth_multiplier;
  logic [7:0]  ref_div_ratio, m_ctl, m_prt, c, p;
  logic [8:0]  exp_q[$];
  logic [7:0]  c_tab[3] = '{8'hac, 8'hff, 8'h80};
  logic [7:0]  p_tab[3] = '{8'hb1, 8'h71, 8'h00};
  int          errors = 0, checked = 0, cycles = 0;
  int          seed = 32'h4d43_b347;
  // Open-drain data line with pull-up
  wire logic   sda_line = ~(sda_low | sda_pin_oe);

  always #2 ref_clk = ~ref_clk;

  // Bench nets carry the port names; only the data line and the tied-low output differ
  tps_serial_ctrl dut (.*, .sda_pin_in(sda_line), .sda_pin_out());

  tps_bus_master u_mst (.ref_clk(ref_clk), .sda_line(sda_line), .scl_out(scl_pin), .sda_low(sda_low),
    .res_valid(res_valid), .res_data(res_data));

  // ==========
  // Checking
  // ==========
  task automatic conclude();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic check_cfg();
    logic g;
    g = m_ctl[5] & m_ctl[3] & m_ctl[2] & ~m_ctl[1];
    checked++;
    if ({loop_divider_count, synth_multiplier, pump_current_select, test_mode_enable, pump_disable,
         test_select_hi, test_select_lo, ref_divider_select, tuning_amp_disable, ref_div_ratio, gen_port_c,
         gen_port_b, gen_port_a, if_output_select, band_switch_out} !== {m_cnt, m_cnt, 1'b0, m_ctl[6:0],
         m_ctl[1] ? 8'h40 : 8'h80, m_prt[7] & ~g, m_prt[5] & ~g, m_prt[4] & ~g, m_prt[6], m_prt[0]}) begin
      errors++;
      $display("wrong value at %0t: outputs differ, count %h ctl %h port %h", $time, m_cnt, m_ctl, m_prt);
    end
  endtask : check_cfg

  // Bus results are paired with the oldest note
  always @(posedge ref_clk) begin
    if (res_valid === 1'b1) begin
      checked++;
      exp_bus = (exp_q.size() > 0) ? exp_q.pop_front() : 9'hxxx;
      if (res_data !== exp_bus) begin
        errors++;
        $display("wrong value at %0t: bus byte %h expected %h", $time, res_data, exp_bus);
      end
    end
  end

  // A hang ends the run as a failure
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      $display("wrong value at %0t: run timed out", $time);
      conclude();
    end
  end

  // ==========
  // Bus sequences
  // ==========
  task automatic put(input logic [7:0] tx, input logic [8:0] e, input logic last);
    exp_q.push_back(e);
    u_mst.xfer(tx, last);
  endtask : put

  task automatic addr(input logic [1:0] a, input logic rd, input logic nack);
    put({5'h18, a, rd}, {5'h18, a, rd, nack}, 1'b1);
  endtask : addr

  task automatic wbyte(input logic [7:0] b);
    put(b, {b, 1'b0}, 1'b1);
  endtask : wbyte

  task automatic div_pair(input logic [14:0] n);
    wbyte({1'b0, n[14:8]});
    check_cfg();
    wbyte(n[7:0]);
    m_cnt = n;
    check_cfg();
  endtask : div_pair

  // ==========
  // Main sequence
  // ==========
  initial begin
    repeat (16) @(negedge ref_clk);
    srst = 1'b0;
    repeat (4) @(negedge ref_clk);
    m_cnt = TPS_RST_COUNT;
    m_ctl = TPS_RST_CTL;
    m_prt = TPS_RST_PORT;
    check_cfg();
    // Each pin setting: a neighbour address is ignored, its own takes a count
    for (int a = 0; a < 4; a++) begin
      {hw_address_bit_hi, hw_address_bit_lo} = a[1:0];
      u_mst.start_cond();
      addr(a[1:0] ^ 2'h1, 1'b0, 1'b1);
      u_mst.stop_cond();
      u_mst.start_cond();
      addr(a[1:0], 1'b0, 1'b0);
      div_pair(15'($random(seed)));
      u_mst.stop_cond();
    end
    // One long transfer: boundary counts, then control and port pairs
    u_mst.start_cond();
    addr(2'h3, 1'b0, 1'b0);
    div_pair(15'h7fff);
    div_pair(15'h0400);
    for (int i = 0; i < 6; i++) begin
      c = (i < 3) ? c_tab[i] : {1'b1, 7'($random(seed))};
      p = (i < 3) ? p_tab[i] : 8'($random(seed));
      wbyte(c);
      m_ctl = c;
      check_cfg();
      wbyte(p);
      m_prt = p;
      check_cfg();
    end
    u_mst.stop_cond();
    // Repeated start drops a lone count byte, committed groups stay
    u_mst.start_cond();
    addr(2'h3, 1'b0, 1'b0);
    div_pair(15'($random(seed)));
    wbyte(8'h2a);
    u_mst.start_cond();
    addr(2'h3, 1'b0, 1'b0);
    wbyte(8'h81);
    m_ctl = 8'h81;
    u_mst.stop_cond();
    check_cfg();
    // Status reads with a slow master; supply dip sets the flag again
    u_mst.q = 15;
    for (int r = 0; r < 2; r++) begin
      {lock_detect_in, level_in_c, level_in_b, level_in_a} = 4'($random(seed));
      supply_ok = (r == 0);
      repeat (8) @(negedge ref_clk);
      supply_ok = 1'b1;
      u_mst.start_cond();
      addr(2'h3, 1'b1, 1'b0);
      put(8'hff, {1'b1, lock_detect_in, level_in_c, level_in_b, level_in_a, 3'h7, 1'b0}, 1'b0);
      put(8'hff, {1'b0, lock_detect_in, level_in_c, level_in_b, level_in_a, 3'h7, 1'b1}, 1'b1);
      u_mst.stop_cond();
    end
    repeat (20) @(negedge ref_clk);
    if (exp_q.size() != 0) begin
      errors++;
      $display("wrong value at %0t: bus results missing", $time);
    end
    conclude();
  end
endmodule : tb_tps_serial_ctrl

bind tps_serial_ctrl tps_serial_ctrl_monitor u_mon (.ref_clk(ref_clk), .srst(srst), .scl_pin(scl_pin),
  .sda_pin_oe(sda_pin_oe), .lock_detect_in(lock_detect_in), .loop_divider_count(loop_divider_count),
  .synth_multiplier(synth_multiplier), .ref_div_ratio(ref_div_ratio), .pump_current_select(pump_current_select),
  .test_mode_enable(test_mode_enable), .test_select_hi(test_select_hi), .test_select_lo(test_select_lo),
  .ref_divider_select(ref_divider_select), .tuning_amp_disable(tuning_amp_disable), .gen_port_a(gen_port_a),
  .gen_port_b(gen_port_b), .gen_port_c(gen_port_c), .pll_locked_status(pll_locked_status));
`default_nettype wire

/* verification/tps_bus_master.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Two-wire bus master model
// ==========
module tps_bus_master (
  input  wire logic       ref_clk,
  input  wire logic       sda_line,
  output var  logic       scl_out,
  output var  logic       sda_low,
  output var  logic       res_valid,
  output var  logic [8:0] res_data
);
  // Quarter bus period in cycles; raised for a slow master
  int q = 5;

  // Idle bus: clock rests high, data released
  initial begin
    scl_out = 1'b1;
    sda_low = 1'b0;
    res_valid = 1'b0;
    res_data = 9'h000;
  end

  task automatic pace();
    repeat (q) @(negedge ref_clk);
  endtask : pace

  // Also a repeated start when entered with the clock low
  task automatic start_cond();
    pace();
    sda_low = 1'b0;
    pace();
    scl_out = 1'b1;
    pace();
    sda_low = 1'b1;
    pace();
    scl_out = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    pace();
    sda_low = 1'b1;
    pace();
    scl_out = 1'b1;
    pace();
    sda_low = 1'b0;
    pace();
  endtask : stop_cond

  // Data moves mid-low, is sampled mid-high
  task automatic one_bit(input logic tx, output logic rx);
    pace();
    sda_low = ~tx;
    pace();
    scl_out = 1'b1;
    pace();
    rx = sda_line;
    pace();
    scl_out = 1'b0;
  endtask : one_bit

  // Reports the byte seen on the wire plus the ninth bit
  task automatic xfer(input logic [7:0] tx, input logic last);
    logic [7:0] rx;
    logic       ack;
    for (int i = 7; i >= 0; i--) begin
      one_bit(tx[i], rx[i]);
    end
    one_bit(last, ack);
    res_data = {rx, ack};
    res_valid = 1'b1;
    @(negedge ref_clk);
    res_valid = 1'b0;
  endtask : xfer
endmodule : tps_bus_master
`default_nettype wire

/* verification/tps_serial_ctrl_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker
// ==========
module tps_serial_ctrl_monitor (
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic        scl_pin,
  input wire logic        sda_pin_oe,
  input wire logic        lock_detect_in,
  input wire logic [14:0] loop_divider_count,
  input wire logic [15:0] synth_multiplier,
  input wire logic [7:0]  ref_div_ratio,
  input wire logic        pump_current_select,
  input wire logic        test_mode_enable,
  input wire logic        test_select_hi,
  input wire logic        test_select_lo,
  input wire logic        ref_divider_select,
  input wire logic        tuning_amp_disable,
  input wire logic        gen_port_a,
  input wire logic        gen_port_b,
  input wire logic        gen_port_c,
  input wire logic        pll_locked_status
);
  // Control view and the port-off test mode
  wire logic [5:0] ctl_v = {pump_current_select, test_mode_enable, test_select_hi, test_select_lo,
                            ref_divider_select, tuning_amp_disable};
  wire logic       port_off = test_mode_enable & test_select_hi & test_select_lo & ~ref_divider_select;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  property p_reset_vals;
    $fell(srst) |-> loop_divider_count == 15'h0000 && !pump_current_select && ref_divider_select
      && tuning_amp_disable && !gen_port_a && !gen_port_b && !gen_port_c && !sda_pin_oe;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

  // Allow a cycle of lag between count and product
  property p_mult;
    $stable(loop_divider_count) ##1 $stable(loop_divider_count) |-> synth_multiplier == {loop_divider_count, 1'b0};
  endproperty
  a_mult: assert property (p_mult) else $error("multiplier not twice count");

  property p_ratio;
    $stable(ref_divider_select) [*2] |-> ref_div_ratio == (ref_divider_select ? 8'h40 : 8'h80);
  endproperty
  a_ratio: assert property (p_ratio) else $error("reference ratio wrong");

  // Data line may only move while the bus clock is low
  property p_oe_rise;
    $rose(sda_pin_oe) |-> !scl_pin && !$past(scl_pin, 2);
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("acknowledge pulled in clock high");

  property p_oe_fall;
    $fell(sda_pin_oe) |-> !scl_pin;
  endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("data line released in clock high");

  // Commits happen at a byte's last bit, with the clock high
  property p_div_commit;
    $changed(loop_divider_count) |-> scl_pin && $past(scl_pin, 2);
  endproperty
  a_div_commit: assert property (p_div_commit) else $error("count moved outside byte end");

  property p_ctl_commit;
    $changed(ctl_v) |-> scl_pin;
  endproperty
  a_ctl_commit: assert property (p_ctl_commit) else $error("control moved outside byte end");

  property p_port_gate;
    port_off [*3] |-> !gen_port_a && !gen_port_b && !gen_port_c;
  endproperty
  a_port_gate: assert property (p_port_gate) else $error("ports on in port-off mode");

  property p_lock;
    $stable(lock_detect_in) [*6] |-> pll_locked_status == lock_detect_in;
  endproperty
  a_lock: assert property (p_lock) else $error("lock status does not follow");
endmodule : tps_serial_ctrl_monitor
`default_nettype wire
